// >>> rtl/pcio_defines.vh
// constants for the port c gpio block: register offsets, field positions, reset values
// assumes a 32-bit axi4-lite slave decoding word-aligned byte addresses
//
// Contract
// (RULE1) eight pins, each with direction, latch, level; usb pins 4 and 5 ignore their direction bits
// (RULE2) direction bit 1 makes pin input, tristated
// (RULE3) direction bit 0 drives latch onto pin
// (RULE4) latch read returns latch, not pin levels
// (RULE5) enabled peripheral may force pin direction
// (RULE6) direction read returns stored bits always
// (RULE7) usb pins: no direction bits, input only
// (RULE8) usb-owned pins follow usb config and status
// (RULE9) external transceiver: usb pins always inputs
// (RULE10) on-chip transceiver: direction follows usb operation
// (RULE11) other pins come up as digital inputs; analog pin 2 comes up analog, its digital buffer off
// (RULE12) analog pin digital only when select bit set
// (RULE13) usb off plus transceiver off frees pins
// (RULE14) on-chip transceiver enabled after reset
// (RULE15) data write updates latch, read returns pins
// (RULE16) reset sets direction bits, latch undefined
`ifndef PCIO_DEFINES_VH
`define PCIO_DEFINES_VH

`define PCIO_OFS_PINS       12'h000
`define PCIO_OFS_LATCH      12'h004
`define PCIO_OFS_DIR        12'h008
`define PCIO_OFS_ANCFG      12'h00C
`define PCIO_OFS_USBCTL     12'h010
`define PCIO_OFS_USBCFG     12'h014
`define PCIO_OFS_STATUS     12'h018

`define PCIO_PIN_ANALOG     2
`define PCIO_PIN_USB_MINUS  4
`define PCIO_PIN_USB_PLUS   5
`define PCIO_ANCFG_CH11_BIT 3
`define PCIO_USBCTL_EN_BIT  3
`define PCIO_USBCFG_XOFF_BIT 3
`define PCIO_USBCFG_EXT_BIT 0

`define PCIO_DIR_RST        8'hFF
`define PCIO_LATCH_RST      8'h00
`define PCIO_ANCFG_RST      8'h00
`define PCIO_USBCTL_RST     8'h00
`define PCIO_USBCFG_RST     8'h00
`define PCIO_USB_PIN_MASK   8'h30

`define PCIO_RESP_OKAY      2'b00
`define PCIO_RESP_SLVERR    2'b10

`endif

// >>> rtl/pcio_pin_cell.v
// pcio_pin_cell: one pin's direction resolve and drive
// assumes override inputs already resolved by the caller
`timescale 1ns/1ps
`default_nettype none
module pcio_pin_cell (
    // configuration
    input  wire dir_bit,
    input  wire latch_bit,
    input  wire has_dir,
    // peripheral override
    input  wire ovr_en,
    input  wire ovr_is_out,
    input  wire ovr_out,
    // usb ownership
    input  wire usb_own,
    input  wire usb_drive,
    input  wire usb_out,
    // pad
    output wire pad_o,
    output wire pad_oe
);
    wire is_input;
    // no direction bit means input unless usb drives
    assign is_input = usb_own ? ~usb_drive :                      // RULE8
                      ~has_dir ? 1'b1 :                           // RULE7
                      ovr_en ? ~ovr_is_out : dir_bit;             // RULE5 RULE2
    assign pad_oe = ~is_input;                                    // RULE2 RULE3
    assign pad_o  = usb_own ? usb_out : (ovr_en ? ovr_out : latch_bit); // RULE3
endmodule // pcio_pin_cell
`default_nettype wire

// >>> rtl/pcio_axil_slave.v
// pcio_axil_slave: axi4-lite handshake, yields one write and one read strobe
// assumes one outstanding write and one outstanding read at a time
`timescale 1ns/1ps
`default_nettype none
`include "pcio_defines.vh"
module pcio_axil_slave (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // write channels
    input  wire [11:0] awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // read channels
    input  wire [11:0] araddr,
    input  wire        arvalid,
    output wire        arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // register side
    output wire        wr_stb,
    output wire [11:0] wr_addr,
    output wire [31:0] wr_data,
    output wire [3:0]  wr_strb,
    input  wire        wr_ok,
    output wire        rd_stb,
    output wire [11:0] rd_addr,
    input  wire [31:0] rd_data,
    input  wire        rd_ok
);
    reg        aw_ff;
    reg        w_ff;
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0]  wstrb_ff;

    assign awready = ~aw_ff & ~bvalid;
    assign wready  = ~w_ff & ~bvalid;
    assign arready = ~rvalid;
    assign wr_stb  = aw_ff & w_ff;
    assign wr_addr = awaddr_ff;
    assign wr_data = wdata_ff;
    assign wr_strb = wstrb_ff;
    assign rd_stb  = arvalid & arready;
    assign rd_addr = araddr;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff  <= 32'h00000000;
            wstrb_ff  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `PCIO_RESP_OKAY;
            rvalid    <= 1'b0;
            rdata     <= 32'h00000000;
            rresp     <= `PCIO_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_stb) begin
                aw_ff  <= 1'b0;
                w_ff   <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wr_ok ? `PCIO_RESP_OKAY : `PCIO_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (rd_stb) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_ok ? `PCIO_RESP_OKAY : `PCIO_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // pcio_axil_slave
`default_nettype wire

// >>> rtl/pcio_port_c.v
// pcio_port_c: 8-pin bidirectional port with latch, direction, usb-shared pins
// assumes pin inputs synchronous to aclk; usb and peripherals supply override levels
`timescale 1ns/1ps
`default_nettype none
`include "pcio_defines.vh"
module pcio_port_c (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // pads
    input  wire [7:0]  pad_i,
    output wire [7:0]  pad_o,
    output wire [7:0]  pad_oe,
    // peripheral overrides, one bit per pin
    input  wire [7:0]  periph_ovr_en,
    input  wire [7:0]  periph_ovr_is_out,
    input  wire [7:0]  periph_ovr_out,
    // usb engine: drive request and data for minus/plus lines
    input  wire        usb_xcvr_drive,
    input  wire [1:0]  usb_xcvr_out,
    // usb status
    output wire        usb_owns_pins,
    output wire        usb_ext_xcvr,
    output wire [1:0]  usb_rx_lines,
    output wire        analog_pin_is_analog
);
    reg  [7:0]  port_c_output_latch_ff;
    reg  [7:0]  port_c_direction_ff;
    reg  [7:0]  analog_config_reg_ff;
    reg  [7:0]  usb_control_reg_ff;
    reg  [7:0]  usb_config_reg_ff;
    reg  [7:0]  port_c_pin_levels_ff;
    reg  [31:0] nxt_rd_data;
    reg         nxt_rd_ok;
    reg         nxt_wr_ok;
    wire        wr_stb;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        rd_stb;
    wire [11:0] rd_addr;
    wire        usb_enabled;
    wire        xcvr_on;
    wire        usb_own;
    wire        ext_xcvr;
    wire [7:0]  has_dir;
    wire [7:0]  dig_in_en;

    // usb owns pins unless module off and on-chip transceiver off or external one selected
    assign usb_enabled = usb_control_reg_ff[`PCIO_USBCTL_EN_BIT];
    assign xcvr_on     = ~usb_config_reg_ff[`PCIO_USBCFG_XOFF_BIT];          // RULE14
    assign ext_xcvr    = usb_config_reg_ff[`PCIO_USBCFG_EXT_BIT];
    assign usb_own     = usb_enabled | (xcvr_on & ~ext_xcvr);                // RULE13
    assign has_dir     = ~`PCIO_USB_PIN_MASK;                                // RULE7

    // analog pin's digital buffer gated by channel eleven select
    assign dig_in_en = {5'h1F, analog_config_reg_ff[`PCIO_ANCFG_CH11_BIT], 2'h3}; // RULE12
    assign analog_pin_is_analog = ~analog_config_reg_ff[`PCIO_ANCFG_CH11_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin                    // RULE1
            wire is_usb;
            wire u_drive;
            wire u_out;
            assign is_usb  = ~has_dir[gi];
            // external transceiver: lines are always receive inputs
            assign u_drive = is_usb & usb_own & ~ext_xcvr & usb_xcvr_drive; // RULE9 RULE10
            assign u_out   = (gi == `PCIO_PIN_USB_PLUS) ? usb_xcvr_out[1] : usb_xcvr_out[0];
            pcio_pin_cell u_cell (
                .dir_bit    (port_c_direction_ff[gi]),
                .latch_bit  (port_c_output_latch_ff[gi]),
                .has_dir    (has_dir[gi]),
                .ovr_en     (periph_ovr_en[gi] & has_dir[gi]),
                .ovr_is_out (periph_ovr_is_out[gi]),
                .ovr_out    (periph_ovr_out[gi]),
                .usb_own    (is_usb & usb_own),
                .usb_drive  (u_drive),
                .usb_out    (u_out),
                .pad_o      (pad_o[gi]),
                .pad_oe     (pad_oe[gi])
            );
        end
    endgenerate

    assign usb_owns_pins = usb_own;
    assign usb_ext_xcvr  = ext_xcvr;
    assign usb_rx_lines  = {pad_i[`PCIO_PIN_USB_PLUS], pad_i[`PCIO_PIN_USB_MINUS]};

    pcio_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (nxt_wr_ok),
        .rd_stb  (rd_stb),
        .rd_addr (rd_addr),
        .rd_data (nxt_rd_data),
        .rd_ok   (nxt_rd_ok)
    );

    // pin levels sampled every cycle; disabled digital buffers read zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_c_pin_levels_ff <= 8'h00;
        end else begin
            port_c_pin_levels_ff <= pad_i & dig_in_en;                     // RULE15 RULE12
        end
    end

    always @* begin
        case (wr_addr)
            `PCIO_OFS_PINS, `PCIO_OFS_LATCH, `PCIO_OFS_DIR,
            `PCIO_OFS_ANCFG, `PCIO_OFS_USBCTL, `PCIO_OFS_USBCFG: nxt_wr_ok = 1'b1;
            default: nxt_wr_ok = 1'b0;
        endcase
    end

    // only byte lane 0 holds data; other lanes ignored
    always @(posedge aclk) begin
        if (!aresetn) begin
            // latch is nominally undefined; zero keeps simulation clean
            port_c_output_latch_ff <= `PCIO_LATCH_RST;                     // RULE16
            port_c_direction_ff    <= `PCIO_DIR_RST;                       // RULE16 RULE11
            analog_config_reg_ff   <= `PCIO_ANCFG_RST;                     // RULE12
            usb_control_reg_ff     <= `PCIO_USBCTL_RST;
            usb_config_reg_ff      <= `PCIO_USBCFG_RST;                    // RULE14
        end else if (wr_stb && wr_strb[0]) begin
            case (wr_addr)
                `PCIO_OFS_PINS:   port_c_output_latch_ff <= wr_data[7:0]; // RULE15
                `PCIO_OFS_LATCH:  port_c_output_latch_ff <= wr_data[7:0]; // RULE4
                `PCIO_OFS_DIR:    port_c_direction_ff    <= wr_data[7:0] | `PCIO_USB_PIN_MASK; // RULE7
                `PCIO_OFS_ANCFG:  analog_config_reg_ff   <= wr_data[7:0];
                `PCIO_OFS_USBCTL: usb_control_reg_ff     <= wr_data[7:0];
                `PCIO_OFS_USBCFG: usb_config_reg_ff      <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    always @* begin
        nxt_rd_data = 32'h00000000;
        nxt_rd_ok   = 1'b1;
        case (rd_addr)
            `PCIO_OFS_PINS:   nxt_rd_data[7:0] = port_c_pin_levels_ff;    // RULE15
            `PCIO_OFS_LATCH:  nxt_rd_data[7:0] = port_c_output_latch_ff;  // RULE4
            `PCIO_OFS_DIR:    nxt_rd_data[7:0] = port_c_direction_ff;     // RULE6
            `PCIO_OFS_ANCFG:  nxt_rd_data[7:0] = analog_config_reg_ff;
            `PCIO_OFS_USBCTL: nxt_rd_data[7:0] = usb_control_reg_ff;
            `PCIO_OFS_USBCFG: nxt_rd_data[7:0] = usb_config_reg_ff;
            `PCIO_OFS_STATUS: nxt_rd_data[7:0] = {5'h00, ~analog_config_reg_ff[`PCIO_ANCFG_CH11_BIT],
                                                  ext_xcvr, usb_own};
            default:          nxt_rd_ok = 1'b0;
        endcase
    end
endmodule // pcio_port_c
`default_nettype wire

// >>> verification/pcio_pad_model.sv
// pad model: the outside world of the eight port pins
// assumes the port wins any contention, so the bench never drives against it
`timescale 1ns/1ps
`default_nettype none
module pcio_pad_model (
    // from the port
    input  wire logic [7:0] pad_o,
    input  wire logic [7:0] pad_oe,
    // level the outside world puts on a released pin
    input  wire logic [7:0] ext_val,
    // back to the port
    output wire logic [7:0] pad_i
);
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_val);
endmodule // pcio_pad_model
`default_nettype wire

// >>> verification/pcio_port_c_asserts.sv
// checker for pcio_port_c: pad resolve, usb pins, bus answer timing
// assumes bind from the bench top; sees the top ports only
`timescale 1ns/1ps
`default_nettype none
module pcio_port_c_asserts (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // pads and overrides
    input wire logic [7:0] pad_i,
    input wire logic [7:0] pad_o,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] periph_ovr_en,
    input wire logic [7:0] periph_ovr_is_out,
    input wire logic [7:0] periph_ovr_out,
    // usb side
    input wire logic       usb_xcvr_drive,
    input wire logic [1:0] usb_xcvr_out,
    input wire logic       usb_owns_pins,
    input wire logic       usb_ext_xcvr,
    input wire logic [1:0] usb_rx_lines,
    input wire logic       analog_pin_is_analog
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // only valid while no override is on, the bench keeps them off in reset
    property p_rst_state;
        $rose(aresetn) && periph_ovr_en == 8'h00 |-> (pad_oe & 8'hCF) == 8'h00 && analog_pin_is_analog && usb_owns_pins && !usb_ext_xcvr;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
    property p_ovr_out;
        (periph_ovr_en & periph_ovr_is_out & 8'hCF & (~pad_oe | (pad_o ^ periph_ovr_out))) == 8'h00;
    endproperty
    a_ovr_out: assert property (p_ovr_out) else $error("forced output not driven");
    property p_ovr_in;
        (periph_ovr_en & ~periph_ovr_is_out & 8'hCF & pad_oe) == 8'h00;
    endproperty
    a_ovr_in: assert property (p_ovr_in) else $error("forced input still driven");
    property p_usb_free;
        !usb_owns_pins |-> pad_oe[5:4] == 2'h0;
    endproperty
    a_usb_free: assert property (p_usb_free) else $error("free usb pins driven");
    property p_usb_ext;
        usb_owns_pins && usb_ext_xcvr |-> pad_oe[5:4] == 2'h0 && usb_rx_lines == pad_i[5:4];
    endproperty
    a_usb_ext: assert property (p_usb_ext) else $error("external mode pins not inputs");
    property p_usb_tx;
        usb_owns_pins && !usb_ext_xcvr |-> pad_oe[5:4] == {2{usb_xcvr_drive}} && (!usb_xcvr_drive || pad_o[5:4] == usb_xcvr_out);
    endproperty
    a_usb_tx: assert property (p_usb_tx) else $error("usb pins not following engine");
    property p_wr_ans;
        // address and data held one cycle before the register strobe, answer on the edge after
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_rd_ans;
        // answer shows next cycle; one cycle later it stands if not taken, else drops
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 (s_axi_rvalid != $past(s_axi_rready));
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule // pcio_port_c_asserts
`default_nettype wire

// >>> verification/test_port_c_bidirectional_io.sv
// bench for pcio_port_c: register tasks over the bus, pad and usb checks
// assumes pcio_pad_model closes the pins; checker bound below
`timescale 1ns/1ps
`default_nettype none
`include "pcio_defines.vh"
module test_port_c_bidirectional_io;
    localparam logic [11:0] A_PIN = `PCIO_OFS_PINS;
    localparam logic [11:0] A_LAT = `PCIO_OFS_LATCH;
    localparam logic [11:0] A_DIR = `PCIO_OFS_DIR;
    localparam logic [11:0] A_ANC = `PCIO_OFS_ANCFG;
    localparam logic [11:0] A_UCT = `PCIO_OFS_USBCTL;
    localparam logic [11:0] A_UCF = `PCIO_OFS_USBCFG;
    localparam logic [11:0] A_STA = `PCIO_OFS_STATUS;
    localparam logic [1:0]  OK = `PCIO_RESP_OKAY;
    localparam logic [1:0]  SE = `PCIO_RESP_SLVERR;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp, usb_rx_lines;
    wire logic [31:0] s_axi_rdata;
    logic [7:0]  periph_ovr_en = 8'h00, periph_ovr_is_out = 8'h00, periph_ovr_out = 8'h00;
    logic [7:0]  ext_val = 8'h3C;
    logic        usb_xcvr_drive = 1'b0;
    logic [1:0]  usb_xcvr_out = 2'h0;
    wire logic [7:0] pad_i, pad_o, pad_oe;
    wire logic   usb_owns_pins, usb_ext_xcvr, analog_pin_is_analog;
    int          n_fail = 0;
    int          check_count = 0;
    logic [1:0]  rsp;
    logic [31:0] rv;
    pcio_port_c i_dut (.*);
    pcio_pad_model i_pads (.pad_o(pad_o), .pad_oe(pad_oe), .ext_val(ext_val), .pad_i(pad_i));
    always #2.5 aclk = ~aclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // handshakes judged at the falling edge, where the combinational readies have settled
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bh;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(rsp, er);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ah, rh;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            rv = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(rv, e);
        chk(rsp, er);
    endtask
    task pad(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] m);
        @(negedge aclk);
        chk(pad_oe, oe);
        chk(pad_o & m, o & m);
    endtask
    task done(input string s);
        $display("test %s finished", s);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_DIR, 32'hFF, OK);
        rd(A_STA, 32'h05, OK);
        chk({analog_pin_is_analog, usb_ext_xcvr, usb_owns_pins}, 32'h5);
        pad(8'h00, 8'h00, 8'h00);
        done("reset");
        wr(A_LAT, 32'hA5, OK);
        rd(A_LAT, 32'hA5, OK);
        wr(A_DIR, 32'h00, OK);
        rd(A_DIR, 32'h30, OK);
        pad(8'hCF, 8'hA5, 8'hCF);
        rd(A_PIN, 32'hB1, OK);
        wr(A_ANC, 32'h08, OK);
        rd(A_PIN, 32'hB5, OK);
        wr(A_PIN, 32'h5A, OK);
        rd(A_LAT, 32'h5A, OK);
        rd(A_PIN, 32'h7A, OK);
        wr(A_DIR, 32'hFF, OK);
        pad(8'h00, 8'h00, 8'h00);
        rd(A_PIN, 32'h3C, OK);
        done("latch");
        @(posedge aclk);
        periph_ovr_en <= 8'h03;
        periph_ovr_is_out <= 8'h01;
        periph_ovr_out <= 8'h01;
        wr(A_DIR, 32'hFD, OK);
        pad(8'h01, 8'h01, 8'h01);
        rd(A_DIR, 32'hFD, OK);
        @(posedge aclk);
        periph_ovr_en <= 8'h00;
        usb_xcvr_drive <= 1'b1;
        usb_xcvr_out <= 2'h2;
        pad(8'h32, 8'h22, 8'h32);
        done("override");
        wr(A_UCT, 32'h08, OK);
        wr(A_UCF, 32'h01, OK);
        rd(A_STA, 32'h03, OK);
        chk({analog_pin_is_analog, usb_ext_xcvr, usb_owns_pins}, 32'h3);
        pad(8'h02, 8'h02, 8'h02);
        chk(usb_rx_lines, 32'h3);
        wr(A_UCT, 32'h00, OK);
        wr(A_UCF, 32'h08, OK);
        rd(A_STA, 32'h00, OK);
        chk({analog_pin_is_analog, usb_ext_xcvr, usb_owns_pins}, 32'h0);
        pad(8'h02, 8'h02, 8'h02);
        rd(A_PIN, 32'h3E, OK);
        wr(A_UCF, 32'h00, OK);
        pad(8'h32, 8'h22, 8'h32);
        done("usb");
        // reset in mid-run: state built up above must be cleared
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_DIR, 32'hFF, OK);
        rd(A_LAT, 32'h00, OK);
        pad(8'h30, 8'h20, 8'h30);
        chk({analog_pin_is_analog, usb_ext_xcvr, usb_owns_pins}, 32'h5);
        done("rereset");
        wr(12'h040, 32'hFF, SE);
        rd(12'h040, 32'h00, SE);
        wr(A_STA, 32'h01, SE);
        done("bus");
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule // test_port_c_bidirectional_io
bind pcio_port_c pcio_port_c_asserts i_chk (.*);
`default_nettype wire
